// >>> rtl/serial_prog_pkg.sv
// Constants for the serial memory programming port
package serial_prog_pkg;
    // ------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------
    localparam int FLASH_WORDS      = 2048;
    localparam int PAGE_WORDS       = 32;
    localparam int WORD_IDX_W       = 5;   // word_in_page_index width
    localparam int PROG_ADDR_TOP    = 10;  // program_address_top_bit
    localparam int EE_BYTES         = 256;
    localparam int EE_PAGE_BYTES    = 4;
    localparam int EE_IDX_W         = 2;
    localparam int EE_ADDR_TOP      = 7;   // eeprom_address_top_bit
    localparam logic [7:0] ERASED   = 8'hFF;
    // ------------------------------------------------------------
    // Instruction opcodes and echo
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ENTRY     = 8'hAC;
    localparam logic [7:0] OP2_ENABLE   = 8'h53;
    localparam logic [7:0] OP2_ERASE    = 8'h80;
    localparam logic [7:0] OP_POLL      = 8'hF0;
    localparam logic [7:0] OP_LOAD_LO   = 8'h40;
    localparam logic [7:0] OP_LOAD_HI   = 8'h48;
    localparam logic [7:0] OP_WR_PAGE   = 8'h4C;
    localparam logic [7:0] OP_RD_LO     = 8'h20;
    localparam logic [7:0] OP_RD_HI     = 8'h28;
    localparam logic [7:0] OP_EE_RD     = 8'hA0;
    localparam logic [7:0] OP_EE_WR     = 8'hC0;
    localparam logic [7:0] OP_EE_LOAD   = 8'hC1;
    localparam logic [7:0] OP_EE_WRPAGE = 8'hC2;
    // ------------------------------------------------------------
    // Timing at 40 MHz
    // ------------------------------------------------------------
    localparam int  CLK_HZ              = 40_000_000;
    localparam real FLASH_PAGE_WAIT_MS  = 4.5;
    localparam real EEPROM_WAIT_MS      = 4.0;
    localparam real ERASE_WAIT_MS       = 4.0;
    localparam int  FLASH_WAIT_CYC = int'(FLASH_PAGE_WAIT_MS * CLK_HZ / 1000.0);
    localparam int  EE_WAIT_CYC    = int'(EEPROM_WAIT_MS * CLK_HZ / 1000.0);
    localparam int  ERASE_WAIT_CYC = int'(ERASE_WAIT_MS * CLK_HZ / 1000.0);
    localparam int  FIFO_DEPTH     = 32;
endpackage

// >>> rtl/byte_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    // Full and empty from extended pointers
    assign in_ready_o  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_q != rd_q;
    assign out_data_o  = mem_q[rd_q[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
        end
    end
endmodule // byte_fifo

// >>> rtl/serial_prog.sv
// Serial in-system programming port for flash and EEPROM
// Function
// - Programming over clock, data-in and data-out only while reset pin is low.
// - No program or erase before a programming-enable instruction after reset low; instructions still queued when reset went high run without it.
// - Every EEPROM write erases the location first; no chip erase needed.
// - Chip erase sets all flash and EEPROM locations to ones.
// - Incoming bits are sampled on the serial clock rising edge.
// - Outgoing bits change on the serial clock falling edge.
// - Enable instruction's second byte echoes during its third byte.
// - Flash page buffer loaded per byte, low byte before high byte.
// - Write-page instruction commits buffer to page in its upper address bits.
// - EEPROM byte write erases then writes; 4.0 ms wait unless polling.
// - EEPROM page write changes only loaded bytes.
// - Flash page is 32 words, index bits 4..0, page bits 10..5.
// - EEPROM page is 4 bytes, index bits 1..0, page bits 7..2.
// - Read instructions shift out the stored content of the addressed location.
// - Reset pin high leaves programming mode.
// - Poll status bit 0 is one while an operation is pending.
// - Chip erase is AC 80 00 00.
// - Program memory instructions take a word address anywhere in range.
`timescale 1ns/1ps
module serial_prog #(
    parameter int FLASH_WAIT = serial_prog_pkg::FLASH_WAIT_CYC,
    parameter int EE_WAIT    = serial_prog_pkg::EE_WAIT_CYC,
    parameter int ERASE_WAIT = serial_prog_pkg::ERASE_WAIT_CYC
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic reset_pin_i,
    input  wire logic sck_i,
    input  wire logic mosi_i,
    output logic      miso_o,
    output logic      miso_oe_o,
    output logic      prog_mode_o,
    output logic      write_pending_poll_o
);
    localparam int FIFO_W = 32;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_s_q;
    logic [1:0] sck_s_q;
    logic [1:0] mosi_s_q;
    logic       sck_d1_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s_q  <= 2'h3;
            sck_s_q  <= 2'h0;
            mosi_s_q <= 2'h0;
            sck_d1_q <= 1'b0;
        end else begin
            rst_s_q  <= {rst_s_q[0], reset_pin_i};
            sck_s_q  <= {sck_s_q[0], sck_i};
            mosi_s_q <= {mosi_s_q[0], mosi_i};
            sck_d1_q <= sck_s_q[1];
        end
    end

    logic in_prog;
    logic sck_rise;
    logic sck_fall;
    assign in_prog  = !rst_s_q[1];
    assign sck_rise = in_prog && sck_s_q[1] && !sck_d1_q;
    assign sck_fall = in_prog && !sck_s_q[1] && sck_d1_q;

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    logic [31:0] sh_q;
    logic [4:0]  bit_q;
    logic [7:0]  out_q;
    logic        word_done;
    logic [7:0]  reply;
    logic        enabled_q;
    logic        busy;
    assign word_done = sck_rise && bit_q == 5'h1F;

    // Collect bits MSB first; count 32 per instruction
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sh_q  <= 32'h0;
            bit_q <= 5'h0;
        end else if (!in_prog) begin
            bit_q <= 5'h0;
        end else if (sck_rise) begin
            sh_q  <= {sh_q[30:0], mosi_s_q[1]};
            bit_q <= bit_q + 5'h1;
        end
    end

    // Arrays read by the reply path; written in the memory section
    logic [15:0] flash_q [serial_prog_pkg::FLASH_WORDS];
    logic [7:0]  ee_q    [serial_prog_pkg::EE_BYTES];

    // Byte of one flash word, address wrapped to the array
    function automatic logic [7:0] flash_rd(input logic hi, input logic [15:0] a);
        logic [15:0] w;
        w = flash_q[a[serial_prog_pkg::PROG_ADDR_TOP:0]];
        return hi ? w[15:8] : w[7:0];
    endfunction

    // Reply byte, loaded at each byte boundary from the bytes so far
    always_comb begin
        reply = 8'h00;
        if (bit_q == 5'h10 && sh_q[15:8] == serial_prog_pkg::OP_ENTRY) begin
            reply = sh_q[7:0];
        end else if (bit_q == 5'h18) begin
            case (sh_q[23:16])
                serial_prog_pkg::OP_POLL:  reply = {7'h00, busy};
                serial_prog_pkg::OP_RD_LO: reply = flash_rd(1'b0, sh_q[15:0]);
                serial_prog_pkg::OP_RD_HI: reply = flash_rd(1'b1, sh_q[15:0]);
                serial_prog_pkg::OP_EE_RD: reply = ee_q[sh_q[7:0]];
                default:                   reply = 8'h00;
            endcase
        end
    end

    // Shift out on falling edge; new byte after each 8th rising edge
    logic load_pending_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_q          <= 8'h00;
            load_pending_q <= 1'b0;
            miso_o         <= 1'b0;
        end else if (!in_prog) begin
            load_pending_q <= 1'b0;
            miso_o         <= 1'b0;
        end else if (sck_rise && bit_q[2:0] == 3'h7) begin
            load_pending_q <= 1'b1;
        end else if (load_pending_q) begin
            out_q          <= reply;
            load_pending_q <= 1'b0;
        end else if (sck_fall) begin
            miso_o <= out_q[7];
            out_q  <= {out_q[6:0], 1'b0};
        end
    end

    // Output enable whenever reset pin is low; mode flag also needs the enable instruction
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            miso_oe_o   <= 1'b0;
            prog_mode_o <= 1'b0;
        end else begin
            miso_oe_o   <= in_prog;
            prog_mode_o <= in_prog && enabled_q;
        end
    end

    // ------------------------------------------------------------
    // Instruction FIFO: received words wait here while a write runs
    // ------------------------------------------------------------
    logic        f_valid;
    logic        f_ready;
    logic [31:0] f_data;
    logic        f_in_ready;
    byte_fifo #(.WIDTH(FIFO_W), .DEPTH(serial_prog_pkg::FIFO_DEPTH)) u_fifo (
        .clk_i      (clk_i),
        .arst_n_i   (arst_n_i),
        .in_valid_i (word_done && enabled_q && f_in_ready),
        .in_ready_o (f_in_ready),
        .in_data_i  ({sh_q[30:0], mosi_s_q[1]}),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready),
        .out_data_o (f_data)
    );

    // Enable instruction seen: unlocks program and erase
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enabled_q <= 1'b0;
        end else if (!in_prog) begin
            enabled_q <= 1'b0;
        end else if (word_done && sh_q[30:23] == serial_prog_pkg::OP_ENTRY
                     && sh_q[22:15] == serial_prog_pkg::OP2_ENABLE) begin
            enabled_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Memories, page buffers and self-timed writes
    // ------------------------------------------------------------
    logic [15:0] fbuf_q  [serial_prog_pkg::PAGE_WORDS];
    logic [7:0]  ebuf_q  [serial_prog_pkg::EE_PAGE_BYTES];
    logic [3:0]  emask_q;
    logic [22:0] wait_q;
    logic        exec;
    logic        do_erase;
    logic        do_fpage;
    logic        do_ebyte;
    logic        do_epage;
    assign busy    = wait_q != 23'h0;
    assign f_ready = in_prog && !busy;

    // Fields of the queued instruction word
    logic [7:0]  op;
    logic [7:0]  op2;
    logic [10:0] waddr;
    logic [7:0]  eaddr;
    logic [7:0]  dat;
    assign op    = f_data[31:24];
    assign op2   = f_data[23:16];
    assign waddr = f_data[18:8];
    assign eaddr = f_data[15:8];
    assign dat   = f_data[7:0];

    // One instruction leaves the queue per cycle while idle
    assign exec     = f_valid && f_ready;
    assign do_erase = exec && op == serial_prog_pkg::OP_ENTRY
                      && op2 == serial_prog_pkg::OP2_ERASE;
    assign do_fpage = exec && op == serial_prog_pkg::OP_WR_PAGE;
    // Byte write needs no prior erase: the old byte is simply replaced
    assign do_ebyte = exec && op == serial_prog_pkg::OP_EE_WR;
    assign do_epage = exec && op == serial_prog_pkg::OP_EE_WRPAGE;

    // Self-timed delay counter; the queue holds while it runs
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_q <= 23'h0;
        end else if (busy) begin
            wait_q <= wait_q - 23'h1;
        end else if (do_erase) begin
            wait_q <= 23'(ERASE_WAIT);
        end else if (do_fpage) begin
            wait_q <= 23'(FLASH_WAIT);
        end else if (do_ebyte || do_epage) begin
            wait_q <= 23'(EE_WAIT);
        end
    end

    // Loaded-byte mask of the EEPROM page buffer
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            emask_q <= 4'h0;
        end else if (do_epage) begin
            emask_q <= 4'h0;
        end else if (exec && op == serial_prog_pkg::OP_EE_LOAD) begin
            emask_q[eaddr[1:0]] <= 1'b1;
        end
    end

    // Flash page buffer; kept after a commit, not cleared by erase
    always_ff @(posedge clk_i) begin
        if (exec && op == serial_prog_pkg::OP_LOAD_LO) begin
            fbuf_q[waddr[4:0]][7:0] <= dat;
        end
        if (exec && op == serial_prog_pkg::OP_LOAD_HI) begin
            fbuf_q[waddr[4:0]][15:8] <= dat;
        end
    end

    // EEPROM page buffer, indexed by the low address bits
    always_ff @(posedge clk_i) begin
        if (exec && op == serial_prog_pkg::OP_EE_LOAD) begin
            ebuf_q[eaddr[1:0]] <= dat;
        end
    end

    // Flash array: chip erase or commit of the whole buffered page
    always_ff @(posedge clk_i) begin
        if (do_erase) begin
            for (int i = 0; i < serial_prog_pkg::FLASH_WORDS; i++) begin
                flash_q[i] <= {2{serial_prog_pkg::ERASED}};
            end
        end else if (do_fpage) begin
            for (int i = 0; i < serial_prog_pkg::PAGE_WORDS; i++) begin
                flash_q[{waddr[10:5], 5'(i)}] <= fbuf_q[i];
            end
        end
    end

    // EEPROM array: erase, byte write with implied erase, or page write
    always_ff @(posedge clk_i) begin
        if (do_erase) begin
            for (int i = 0; i < serial_prog_pkg::EE_BYTES; i++) begin
                ee_q[i] <= serial_prog_pkg::ERASED;
            end
        end else if (do_ebyte) begin
            ee_q[eaddr] <= dat;
        end else if (do_epage) begin
            for (int i = 0; i < serial_prog_pkg::EE_PAGE_BYTES; i++) begin
                if (emask_q[i]) begin
                    ee_q[{eaddr[7:2], 2'(i)}] <= ebuf_q[i];
                end
            end
        end
    end

    // Poll pin mirrors the pending state
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            write_pending_poll_o <= 1'b0;
        end else begin
            write_pending_poll_o <= busy;
        end
    end
endmodule // serial_prog

// >>> dv/serial_prog_chk.sv
// Assertion checker for the serial programming port
`timescale 1ns/1ps
module serial_prog_chk #(
    parameter int FLASH_WAIT = 20,
    parameter int EE_WAIT    = 20,
    parameter int ERASE_WAIT = 20
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic reset_pin_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic miso_o,
    input wire logic miso_oe_o,
    input wire logic prog_mode_o,
    input wire logic write_pending_poll_o
);
    localparam int PEND_MAX = 40 * (FLASH_WAIT + EE_WAIT + ERASE_WAIT);
    logic        sck_q;
    logic [3:0]  fall_q;
    logic [3:0]  rise_q;
    logic [15:0] pend_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // ----------------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------------
    // Cycles since raw serial clock edges, saturating
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_q  <= 1'b0;
            fall_q <= 4'hF;
            rise_q <= 4'hF;
        end else begin
            sck_q  <= sck_i;
            fall_q <= (sck_q && !sck_i) ? 4'h0 : (fall_q == 4'hF) ? fall_q : fall_q + 4'h1;
            rise_q <= (!sck_q && sck_i) ? 4'h0 : (rise_q == 4'hF) ? rise_q : rise_q + 4'h1;
        end
    end
    // Length of the current pending run
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pend_q <= 16'h0000;
        end else begin
            pend_q <= write_pending_poll_o ? pend_q + 16'h0001 : 16'h0000;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    oe_on_a: assert property ((!reset_pin_i) [*5] |-> miso_oe_o)
        else $error("miso not driven in session");
    oe_off_a: assert property (reset_pin_i [*5] |-> !miso_oe_o)
        else $error("miso driven outside session");
    mode_off_a: assert property (reset_pin_i [*5] |-> !prog_mode_o)
        else $error("program mode kept after reset pin high");
    mode_hold_a: assert property ((!reset_pin_i) [*6] ##0 prog_mode_o |=> prog_mode_o)
        else $error("program mode lost in session");
    mode_rise_a: assert property ($rose(prog_mode_o) |-> miso_oe_o && rise_q <= 4'h6)
        else $error("program mode not started by a clock rise");
    miso_edge_a: assert property ((!reset_pin_i) [*6] ##0 $changed(miso_o) |-> fall_q <= 4'h6)
        else $error("miso changed away from a falling edge");
    pend_rise_a: assert property ($rose(write_pending_poll_o) |-> prog_mode_o)
        else $error("write started without program mode");
    pend_bound_a: assert property (write_pending_poll_o |-> pend_q < PEND_MAX)
        else $error("pending write never ends");
    mode_c: cover property ($rose(prog_mode_o));
    pend_c: cover property ($fell(write_pending_poll_o));
    oe_c: cover property ($rose(miso_oe_o));
endmodule // serial_prog_chk

bind serial_prog serial_prog_chk #(
    .FLASH_WAIT(FLASH_WAIT),
    .EE_WAIT(EE_WAIT),
    .ERASE_WAIT(ERASE_WAIT)
) serial_prog_chk_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .reset_pin_i(reset_pin_i), .sck_i(sck_i),
    .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .prog_mode_o(prog_mode_o),
    .write_pending_poll_o(write_pending_poll_o)
);

// >>> dv/isp_programmer.sv
// Programmer model driving the serial programming pins
`timescale 1ns/1ps
module isp_programmer #(
    parameter int HALF   = 4,
    parameter int SETTLE = 40
) (
    input  wire logic clk_i,
    input  wire logic miso_i,
    output logic      reset_pin_o = 1'b1,
    output logic      sck_o       = 1'b0,
    output logic      mosi_o      = 1'b0
);
    // Half serial period, above three system cycles
    task automatic half_wait();
        repeat (HALF) @(negedge clk_i);
    endtask
    // One whole instruction, MSB first; reply taken at each rise
    task automatic xfer(input logic [31:0] ins, output logic [31:0] rsp);
        for (int i = 31; i >= 0; i--) begin
            mosi_o = ins[i];
            half_wait();
            sck_o  = 1'b1;
            rsp[i] = miso_i;
            half_wait();
            sck_o  = 1'b0;
        end
        mosi_o = ~mosi_o;
        half_wait();
    endtask
    // Reset pulse with clock low, then low reset and settle
    task automatic pulse();
        reset_pin_o = 1'b1;
        repeat (4) @(negedge clk_i);
        reset_pin_o = 1'b0;
        repeat (SETTLE) @(negedge clk_i);
    endtask
    // Enter programming, retrying while the echo is missing
    task automatic start(output logic ok);
        logic [31:0] r;
        ok = 1'b0;
        for (int n = 0; n < 3 && !ok; n++) begin
            pulse();
            xfer(32'hAC53_0000, r);
            ok = (r[15:8] === 8'h53);
        end
    endtask
    // Poll until idle; reports whether busy was seen
    task automatic poll(output logic busy);
        logic [31:0] r;
        busy = 1'b0;
        for (int n = 0; n < 20; n++) begin
            xfer(32'hF000_0000, r);
            if (r[0] !== 1'b1) break;
            busy = 1'b1;
        end
    endtask
endmodule // isp_programmer

// >>> dv/serial_prog_tb_top.sv
// Testbench for the serial programming port
`timescale 1ns/1ps
module serial_prog_tb_top;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        reset_pin, sck, mosi, miso, miso_oe, prog_mode, pend, miso_w, ok;
    logic [31:0] r;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;
    // Floating line shows the inverse of the last level
    assign miso_w = miso_oe ? miso : ~miso;
    serial_prog #(.FLASH_WAIT(600), .EE_WAIT(500), .ERASE_WAIT(500)) serial_prog_i (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .reset_pin_i(reset_pin), .sck_i(sck),
        .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .prog_mode_o(prog_mode),
        .write_pending_poll_o(pend)
    );
    isp_programmer isp_programmer_i (
        .clk_i(clk_i), .miso_i(miso_w), .reset_pin_o(reset_pin), .sck_o(sck), .mosi_o(mosi)
    );
    // Clock and hang guard
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    // Compare one byte
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Read instruction whose last byte holds the expected value
    task automatic rd(input logic [31:0] q, input string nm);
        isp_programmer_i.xfer({q[31:8], 8'h00}, r);
        chk(nm, q[7:0], r[7:0]);
    endtask
    // Erase, then writes refused before enable
    task automatic t_erase_refuse();
        isp_programmer_i.start(ok);
        chk("echo", 8'h01, {7'h0, ok});
        repeat (5) @(negedge clk_i);
        chk("mode on", 8'h01, {7'h0, prog_mode});
        chk("oe on", 8'h01, {7'h0, miso_oe});
        isp_programmer_i.xfer(32'hAC80_0000, r);
        isp_programmer_i.poll(ok);
        chk("erase busy", 8'h01, {7'h0, ok});
        rd(32'hA000_05FF, "ee erased");
        rd(32'h2007_00FF, "flash erased");
        isp_programmer_i.pulse();
        chk("mode off", 8'h00, {7'h0, prog_mode});
        isp_programmer_i.xfer(32'hC000_05A5, r);
        repeat (8) @(negedge clk_i);
        chk("refused", 8'h00, {7'h0, pend});
        isp_programmer_i.start(ok);
        rd(32'hA000_05FF, "ee kept");
        $display("test erase_refuse done");
    endtask
    // Byte writes over old data
    task automatic t_ee_byte();
        isp_programmer_i.xfer(32'hC000_05A5, r);
        repeat (8) @(negedge clk_i);
        chk("ee pending", 8'h01, {7'h0, pend});
        isp_programmer_i.poll(ok);
        rd(32'hA000_05A5, "ee byte");
        isp_programmer_i.xfer(32'hC000_055A, r);
        isp_programmer_i.poll(ok);
        rd(32'hA000_055A, "ee rewrite");
        rd(32'hA000_04FF, "ee neighbour");
        $display("test ee_byte done");
    endtask
    // Page write changes only loaded bytes
    task automatic t_ee_page();
        logic [31:0] q[4] = '{32'hA000_08FF, 32'hA000_0911, 32'hA000_0A22, 32'hA000_0BFF};
        isp_programmer_i.xfer(32'hC100_0111, r);
        isp_programmer_i.xfer(32'hC100_0222, r);
        isp_programmer_i.xfer(32'hC200_0800, r);
        isp_programmer_i.poll(ok);
        foreach (q[i]) rd(q[i], "ee page");
        $display("test ee_page done");
    endtask
    // Flash page load, low byte first, commit and read back
    task automatic t_flash_page();
        logic [31:0] ld[4] = '{32'h4000_A334, 32'h4800_A312, 32'h4000_BF78, 32'h4800_BF56};
        logic [31:0] q[5] = '{32'h2000_A334, 32'h2800_A312, 32'h2000_BF78,
                              32'h2800_BF56, 32'h2000_C3FF};
        foreach (ld[i]) isp_programmer_i.xfer(ld[i], r);
        isp_programmer_i.xfer(32'h4C00_A000, r);
        isp_programmer_i.poll(ok);
        chk("flash busy", 8'h01, {7'h0, ok});
        foreach (q[i]) rd(q[i], "flash page");
        $display("test flash_page done");
    endtask
    // Verdict
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        t_erase_refuse();
        t_ee_byte();
        t_ee_page();
        t_flash_page();
        tally_and_finish();
    end
endmodule // serial_prog_tb_top
